// file: pkg/pwmtb_consts.svh
/*
 * Offsets, field positions, reset values and codes of the PWM time base B.
 * Assumes inclusion by the package, the main module, the checker and the bench.
 */
`ifndef PWMTB_CONSTS_SVH
`define PWMTB_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PWMTB_OFF_CTRL 6'h00
`define PWMTB_OFF_CNT 6'h04
`define PWMTB_OFF_MOD 6'h08
`define PWMTB_OFF_DUTY0 6'h0C
`define PWMTB_OFF_DUTY1 6'h10
`define PWMTB_OFF_POL 6'h14
`define PWMTB_OFF_STAT 6'h18

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PWMTB_CTRL_SPLIT 0
`define PWMTB_CTRL_EDGE 1
`define PWMTB_CTRL_DIV_LO 2
`define PWMTB_CTRL_RLD_LO 4
`define PWMTB_CTRL_LDOK 8

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define PWMTB_RST_MOD 15'h0010
`define PWMTB_RST_DUTY 15'h0008
`define PWMTB_RST_DIV 2'h0
`define PWMTB_RST_RLD 4'h0
`define PWMTB_RESP_OKAY 2'h0
`define PWMTB_RESP_SLVERR 2'h2

`endif

// file: pkg/pwmtb_pkg.sv
/*
 * Types of the PWM time base B.
 * Assumes the constants header is on the include path.
 */
package pwmtb_pkg;
    `include "pwmtb_consts.svh"

    // one generator setting, buffered and active copies alike
    typedef struct packed {
        logic [14:0] modulus;
        logic [14:0] duty0;
        logic [14:0] duty1;
        logic [1:0] div;
    } pwmtb_set_type;

    // software control bits
    typedef struct packed {
        logic split;
        logic edge_mode;
        logic [3:0] reload;
        logic [1:0] pol;
    } pwmtb_ctrl_type;

    // counting direction
    typedef enum logic [1:0] {
        PWMTB_UP = 2'b01,
        PWMTB_DOWN = 2'b10
    } pwmtb_dir_type;
endpackage

// file: verilog/pwmtb_prescaler.sv
/*
 * Core clock prescaler: one tick every 1, 2, 4 or 8 clocks.
 * Assumes div is stable between reload points.
 */
module pwmtb_prescaler
    import pwmtb_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic [1:0] div_i,
    // tick
    output logic tick_o
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    wire [2:0] top_w = 3'((4'h1 << div_i) - 4'h1);

    // divider count
    assign tick_o = run_i && (cnt_r >= top_w);
    assign cnt_nxt = (!run_i || tick_o) ? 3'h0 : 3'(cnt_r + 3'h1);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// file: verilog/pwmtb_top.sv
/*
 * PWM generator time base B with an AXI4-Lite register slave.
 * Assumes one clock domain and a single AXI4-Lite master.
 */
// The address map and the AXI4-Lite slave port were chosen for this implementation.
// Notes on behaviour
// - reload every field plus one opportunities
// - divide code selects core clock by 1,2,4,8
// - divisor buffered until load ok and reload
// - counter read only, zero when split clear
// - modulus writable only when split set
// - modulus is 15-bit period in PWM clocks
// - 15-bit up/down counter, compare set outputs
// - alignment bit selects edge or center
// - period modulus, or twice in center
// - pulse duty, or twice duty less one in center
// - polarity bit per channel inverts output
// - down and duty above counter: high
// - up and counter equals duty: low
`include "pwmtb_consts.svh"
module pwmtb_top
    import pwmtb_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // axi write address and data
    input wire logic [5:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // axi write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi read
    input wire logic [5:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // compare outputs to the power stage
    output logic [1:0] pwm_o
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    pwmtb_ctrl_type ctrl_r;
    pwmtb_set_type buf_r;
    pwmtb_set_type act_r;
    pwmtb_dir_type dir_r;
    pwmtb_dir_type dir_nxt;
    logic load_ok_r;
    logic [14:0] cnt_r;
    logic [14:0] cnt_nxt;
    logic [3:0] opp_r;
    logic [3:0] opp_nxt;
    logic [1:0] raw_r;
    logic [1:0] raw_nxt;
    logic [1:0] pwm_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // byte-lane merge of a write onto an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    // address decode to a one-hot register select
    function automatic logic [6:0] decode(input logic [5:0] a);
        logic [6:0] sel;
        sel = 7'h00;
        unique case (a)
            `PWMTB_OFF_CTRL: sel = 7'h01;
            `PWMTB_OFF_CNT: sel = 7'h02;
            `PWMTB_OFF_MOD: sel = 7'h04;
            `PWMTB_OFF_DUTY0: sel = 7'h08;
            `PWMTB_OFF_DUTY1: sel = 7'h10;
            `PWMTB_OFF_POL: sel = 7'h20;
            `PWMTB_OFF_STAT: sel = 7'h40;
            default: sel = 7'h00;
        endcase
        return sel;
    endfunction

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r;
    wire rd_go = s_axi_arvalid_i && !rvalid_r;
    wire [6:0] wsel = decode(s_axi_awaddr_i);
    wire [6:0] rsel = decode(s_axi_araddr_i);
    wire [31:0] ctrl_word = {23'h0, load_ok_r, ctrl_r.reload, buf_r.div, ctrl_r.edge_mode, ctrl_r.split};
    wire [31:0] ctrl_wr = merge(ctrl_word, s_axi_wdata_i, s_axi_wstrb_i);
    wire [31:0] mod_wr = merge({17'h0, buf_r.modulus}, s_axi_wdata_i, s_axi_wstrb_i);
    wire [31:0] d0_wr = merge({17'h0, buf_r.duty0}, s_axi_wdata_i, s_axi_wstrb_i);
    wire [31:0] d1_wr = merge({17'h0, buf_r.duty1}, s_axi_wdata_i, s_axi_wstrb_i);
    wire [31:0] pol_wr = merge({30'h0, ctrl_r.pol}, s_axi_wdata_i, s_axi_wstrb_i);
    wire wr_ctrl = wr_go && wsel[0];
    wire wr_mod = wr_go && wsel[2] && ctrl_r.split;
    wire wr_d0 = wr_go && wsel[3];
    wire wr_d1 = wr_go && wsel[4];
    wire wr_pol = wr_go && wsel[5];
    // counter and status are read only, so writes there are refused
    wire wr_bad = (wsel == 7'h00) || wsel[1] || wsel[6];
    wire set_ldok = wr_ctrl && ctrl_wr[`PWMTB_CTRL_LDOK];

    assign s_axi_awready_o = wr_go;
    assign s_axi_wready_o = wr_go;
    assign s_axi_arready_o = rd_go;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    // read mux
    wire [31:0] rd_word =
        rsel[0] ? ctrl_word :
        rsel[1] ? (ctrl_r.split ? {17'h0, cnt_r} : 32'h0) :
        rsel[2] ? (ctrl_r.split ? {17'h0, buf_r.modulus} : 32'h0) :
        rsel[3] ? {17'h0, buf_r.duty0} :
        rsel[4] ? {17'h0, buf_r.duty1} :
        rsel[5] ? {30'h0, ctrl_r.pol} :
        rsel[6] ? {26'h0, pwm_r, raw_r, dir_r == PWMTB_DOWN, ctrl_r.split} : 32'h0;

    // ------------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------------
    logic tick;

    pwmtb_prescaler u_presc (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .run_i(ctrl_r.split),
        .div_i(act_r.div),
        .tick_o(tick)
    );

    // end of period in either alignment marks a reload opportunity
    wire edge_m = ctrl_r.edge_mode;
    wire [14:0] last_edge = 15'(act_r.modulus - 15'h1);
    wire at_top = (cnt_r >= act_r.modulus);
    wire edge_wrap = edge_m && (cnt_r >= last_edge);
    wire ctr_wrap = !edge_m && (dir_r == PWMTB_DOWN) && (cnt_r <= 15'h1);
    wire opp = tick && (edge_wrap || ctr_wrap);
    wire opp_hit = opp && (opp_r >= ctrl_r.reload);
    wire reload = opp_hit && load_ok_r;

    // counter sequencing
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (tick) begin
            if (edge_m) begin
                dir_nxt = PWMTB_UP;
                cnt_nxt = edge_wrap ? 15'h0 : 15'(cnt_r + 15'h1);
            end else begin
                unique case (dir_r)
                    PWMTB_UP: begin
                        if (at_top) begin
                            dir_nxt = PWMTB_DOWN;
                            cnt_nxt = 15'(cnt_r - 15'h1);
                        end else begin
                            cnt_nxt = 15'(cnt_r + 15'h1);
                        end
                    end
                    PWMTB_DOWN: begin
                        if (ctr_wrap) begin
                            dir_nxt = PWMTB_UP;
                            cnt_nxt = 15'h0;
                        end else begin
                            cnt_nxt = 15'(cnt_r - 15'h1);
                        end
                    end
                    default: begin
                        dir_nxt = PWMTB_UP;
                        cnt_nxt = 15'h0;
                    end
                endcase
            end
        end
    end

    assign opp_nxt = opp ? (opp_hit ? 4'h0 : 4'(opp_r + 4'h1)) : opp_r;

    // compare logic for both channels
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
            wire [14:0] duty = (ch == 0) ? act_r.duty0 : act_r.duty1;
            wire up_eq = tick && (dir_nxt == PWMTB_UP) && (cnt_nxt == duty);
            wire dn_gt = tick && (dir_nxt == PWMTB_DOWN) && (duty > cnt_nxt);
            wire edge_start = tick && edge_m && (cnt_nxt == 15'h0);
            always_comb begin
                raw_nxt[ch] = raw_r[ch];
                if (up_eq) begin
                    raw_nxt[ch] = 1'b0;
                end else if (dn_gt || edge_start) begin
                    raw_nxt[ch] = 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------

    // software registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '{split: 1'b0, edge_mode: 1'b0, reload: `PWMTB_RST_RLD, pol: 2'h0};
            buf_r <= '{modulus: `PWMTB_RST_MOD, duty0: `PWMTB_RST_DUTY, duty1: `PWMTB_RST_DUTY, div: `PWMTB_RST_DIV};
        end else begin
            if (wr_ctrl) begin
                ctrl_r.split <= ctrl_wr[`PWMTB_CTRL_SPLIT];
                ctrl_r.edge_mode <= ctrl_wr[`PWMTB_CTRL_EDGE];
                ctrl_r.reload <= ctrl_wr[`PWMTB_CTRL_RLD_LO +: 4];
                buf_r.div <= ctrl_wr[`PWMTB_CTRL_DIV_LO +: 2];
            end
            if (wr_mod) begin
                buf_r.modulus <= mod_wr[14:0];
            end
            if (wr_d0) begin
                buf_r.duty0 <= d0_wr[14:0];
            end
            if (wr_d1) begin
                buf_r.duty1 <= d1_wr[14:0];
            end
            if (wr_pol) begin
                ctrl_r.pol <= pol_wr[1:0];
            end
        end
    end

    // load ok: a set in the reload cycle wins over the clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            load_ok_r <= 1'b0;
        end else if (set_ldok) begin
            load_ok_r <= 1'b1;
        end else if (reload) begin
            load_ok_r <= 1'b0;
        end
    end

    // generator state, held at rest while split select is clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !ctrl_r.split) begin
            act_r <= '{modulus: `PWMTB_RST_MOD, duty0: `PWMTB_RST_DUTY, duty1: `PWMTB_RST_DUTY, div: `PWMTB_RST_DIV};
            cnt_r <= 15'h0;
            dir_r <= PWMTB_UP;
            opp_r <= 4'h0;
            raw_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
            opp_r <= opp_nxt;
            raw_r <= raw_nxt;
            if (reload) begin
                act_r <= buf_r;
            end
        end
    end

    // polarity applied in the output flop
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pwm_r <= 2'h0;
        end else begin
            pwm_r <= raw_nxt ^ ctrl_r.pol;
        end
    end

    assign pwm_o = pwm_r;

    // write response
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= `PWMTB_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_bad ? `PWMTB_RESP_SLVERR : `PWMTB_RESP_OKAY;
        end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // read response
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `PWMTB_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= (rsel == 7'h00) ? `PWMTB_RESP_SLVERR : `PWMTB_RESP_OKAY;
        end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// file: verif/pwmtb_stage.sv
/*
 * Power stage model: measures period and high time of both compare outputs.
 * Assumes one clock shared with the generator.
 */
module pwmtb_stage (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // compare outputs from the generator
    input wire logic [1:0] pwm_i,
    // last full period and high time per channel, in core clocks
    output logic [1:0][15:0] per_o,
    output logic [1:0][15:0] wid_o
);
    logic [1:0] last_r;
    logic [1:0][15:0] run_r;
    logic [1:0][15:0] hi_r;

    // rise to rise counting per channel
    always_ff @(posedge clock_i) begin
        last_r <= pwm_i;
        for (int i = 0; i < 2; i++) begin
            if (!rst_n_i) begin
                run_r[i] <= 16'h0000;
                hi_r[i] <= 16'h0000;
                per_o[i] <= 16'h0000;
                wid_o[i] <= 16'h0000;
            end else if (pwm_i[i] && !last_r[i]) begin
                per_o[i] <= run_r[i];
                wid_o[i] <= hi_r[i];
                run_r[i] <= 16'h0001;
                hi_r[i] <= 16'h0001;
            end else begin
                run_r[i] <= run_r[i] + 16'h0001;
                hi_r[i] <= hi_r[i] + {15'h0000, pwm_i[i]};
            end
        end
    end
endmodule

// file: verif/pwmtb_top_chk.sv
/*
 * Port checker of the PWM time base B, bound to the top module.
 * Assumes full-word register writes and software tracking of split and polarity.
 */
`include "pwmtb_consts.svh"
module pwmtb_top_chk (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // axi signals watched
    input wire logic [5:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [5:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // compare outputs
    input wire logic [1:0] pwm_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic split_r;
    logic [1:0] pol_r;
    logic [1:0] idle_r;
    wire logic wr_take = s_axi_awvalid_i && s_axi_awready_o;
    wire logic rd_take = s_axi_arvalid_i && s_axi_arready_o;
    wire logic ctrl_wr = wr_take && (s_axi_awaddr_i == `PWMTB_OFF_CTRL);
    wire logic pol_wr = wr_take && (s_axi_awaddr_i == `PWMTB_OFF_POL);

    // shadow of split and polarity, cycles spent idle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            split_r <= 1'b0;
            pol_r <= 2'h0;
            idle_r <= 2'h0;
        end else begin
            if (ctrl_wr) split_r <= s_axi_wdata_i[0];
            if (pol_wr) pol_r <= s_axi_wdata_i[1:0];
            if (ctrl_wr || pol_wr || split_r) idle_r <= 2'h0;
            else if (idle_r != 2'h3) idle_r <= idle_r + 2'h1;
        end
    end

    property p_cnt_wr; wr_take && s_axi_awaddr_i == `PWMTB_OFF_CNT |=> s_axi_bvalid_o && s_axi_bresp_o == `PWMTB_RESP_SLVERR; endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write not refused");
    property p_mod_wr; wr_take && s_axi_awaddr_i == `PWMTB_OFF_MOD |=> s_axi_bresp_o == `PWMTB_RESP_OKAY; endproperty
    a_mod_wr: assert property (p_mod_wr) else $error("modulus write not okay");
    property p_cnt_rd; rd_take && s_axi_araddr_i == `PWMTB_OFF_CNT && !split_r |=> s_axi_rdata_o == 32'h0; endproperty
    a_cnt_rd: assert property (p_cnt_rd) else $error("counter not zero");
    property p_mod_rd; rd_take && s_axi_araddr_i == `PWMTB_OFF_MOD && !split_r |=> s_axi_rdata_o == 32'h0; endproperty
    a_mod_rd: assert property (p_mod_rd) else $error("modulus not zero");
    property p_idle; idle_r == 2'h3 |-> pwm_o == pol_r; endproperty
    a_idle: assert property (p_idle) else $error("idle level wrong");
    property p_unmap; rd_take && s_axi_araddr_i > `PWMTB_OFF_STAT |=> s_axi_rresp_o == `PWMTB_RESP_SLVERR; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read okay");
    property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_rans; rd_take |=> s_axi_rvalid_o; endproperty
    a_rans: assert property (p_rans) else $error("read answer missing");
endmodule
bind pwmtb_top pwmtb_top_chk i_pwmtb_top_chk (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pwm_o);

// file: verif/pwmtb_top_bench.sv
/*
 * Self-checking bench of the PWM time base B: axi master tasks and scenarios.
 * Assumes the checker is bound and the power stage model measures the outputs.
 */
`include "pwmtb_consts.svh"
module pwmtb_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] s_axi_awaddr_i = 6'h00;
    logic [5:0] s_axi_araddr_i = 6'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'b0;
    logic s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, pwm_o;
    logic [31:0] s_axi_rdata_o;
    logic [1:0][15:0] per, wid;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int lag = 0;

    // clock and cycle count
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;

    pwmtb_top i_pwmtb_top (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pwm_o);
    pwmtb_stage i_pwmtb_stage (.clock_i, .rst_n_i, .pwm_i(pwm_o), .per_o(per), .wid_o(wid));

    // ------------------------------------------------------------------------
    // report, compare and bus tasks
    // ------------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang();
        chk(32'h0, 32'h1);
        tally_and_finish();
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clock_i);
            if (s_axi_awready_o === 1'b1 && s_axi_wready_o === 1'b1) break;
        end
        if (n == 100) hang();
        @(posedge clock_i);
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        // optional late response ready, so the response must stand
        repeat (lag) @(posedge clock_i);
        s_axi_bready_i <= 1'b1;
        for (n = 0; n < 100; n++) begin @(negedge clock_i); if (s_axi_bvalid_o === 1'b1) break; end
        if (n == 100) hang();
        r = s_axi_bresp_o;
        @(posedge clock_i);
        s_axi_bready_i <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        for (n = 0; n < 100; n++) begin @(negedge clock_i); if (s_axi_arready_o === 1'b1) break; end
        if (n == 100) hang();
        @(posedge clock_i);
        s_axi_arvalid_i <= 1'b0;
        repeat (lag) @(posedge clock_i);
        s_axi_rready_i <= 1'b1;
        for (n = 0; n < 100; n++) begin @(negedge clock_i); if (s_axi_rvalid_o === 1'b1) break; end
        if (n == 100) hang();
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        @(posedge clock_i);
        s_axi_rready_i <= 1'b0;
    endtask
    function automatic logic [31:0] ctrl(input logic ed, input logic [1:0] dv, input logic [3:0] rl, input logic lk);
        return {23'h0, lk, rl, dv, ed, 1'b1};
    endfunction

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic s_regs();
        logic [31:0] d, e;
        logic [1:0] r;
        wr(`PWMTB_OFF_CTRL, 32'h0, r);
        rd(`PWMTB_OFF_MOD, d, r);
        chk(d, 32'h0);
        rd(`PWMTB_OFF_CNT, d, r);
        chk(d, 32'h0);
        rd(`PWMTB_OFF_STAT, d, r);
        chk(d, 32'h0);
        chk(r, `PWMTB_RESP_OKAY);
        wr(`PWMTB_OFF_MOD, 32'h5, r);
        chk(r, `PWMTB_RESP_OKAY);
        lag = 2;
        wr(`PWMTB_OFF_CNT, 32'h3, r);
        chk(r, `PWMTB_RESP_SLVERR);
        rd(6'h1C, d, r);
        chk(r, `PWMTB_RESP_SLVERR);
        chk(d, 32'h0);
        lag = 0;
        wr(`PWMTB_OFF_CTRL, ctrl(1'b1, 2'h0, 4'h0, 1'b0), r);
        rd(`PWMTB_OFF_MOD, d, r);
        chk(d, `PWMTB_RST_MOD);
        wr(`PWMTB_OFF_MOD, 32'hFFFFFFFF, r);
        rd(`PWMTB_OFF_MOD, d, r);
        chk(d, 32'h7FFF);
        rd(`PWMTB_OFF_CNT, d, r);
        rd(`PWMTB_OFF_CNT, e, r);
        chk({31'h0, d < 16 && e < 16 && d != e}, 32'h1);
    endtask
    // new setting loaded at the first reload opportunity, then period and high time of both channels
    task automatic s_wave(input logic ed, input logic [1:0] dv, input logic [14:0] m, input logic [14:0] d0,
        input logic [14:0] d1, input logic [1:0] pl, input int ep, input int w0, input int w1);
        logic [1:0] r;
        wr(`PWMTB_OFF_MOD, {17'h0, m}, r);
        wr(`PWMTB_OFF_DUTY0, {17'h0, d0}, r);
        wr(`PWMTB_OFF_DUTY1, {17'h0, d1}, r);
        wr(`PWMTB_OFF_POL, {30'h0, pl}, r);
        wr(`PWMTB_OFF_CTRL, ctrl(ed, dv, 4'h0, 1'b1), r);
        repeat (600) @(posedge clock_i);
        chk(per[0], ep);
        chk(wid[0], w0);
        chk(per[1], ep);
        chk(wid[1], w1);
    endtask
    task automatic s_hold();
        logic [1:0] r;
        wr(`PWMTB_OFF_MOD, 32'h7, r);
        wr(`PWMTB_OFF_CTRL, ctrl(1'b1, 2'h1, 4'h0, 1'b0), r);
        repeat (300) @(posedge clock_i);
        chk(per[0], 40);
        wr(`PWMTB_OFF_CTRL, ctrl(1'b1, 2'h1, 4'h0, 1'b1), r);
        repeat (400) @(posedge clock_i);
        chk(per[0], 14);
    endtask
    task automatic poll(output int t);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        for (n = 0; n < 300; n++) begin rd(`PWMTB_OFF_CTRL, d, r); if (d[8] === 1'b0) break; end
        if (n == 300) hang();
        t = cyc;
    endtask
    // spacing of two loads at reload codes 4 and 15, period of 8 clocks
    task automatic s_reload(input logic [3:0] c);
        logic [1:0] r;
        int t1, t2, ex;
        ex = (c + 1) * 8;
        wr(`PWMTB_OFF_MOD, 32'h8, r);
        wr(`PWMTB_OFF_CTRL, ctrl(1'b1, 2'h0, c, 1'b1), r);
        poll(t1);
        wr(`PWMTB_OFF_CTRL, ctrl(1'b1, 2'h0, c, 1'b1), r);
        poll(t2);
        chk({31'h0, t2 - t1 >= ex - 6 && t2 - t1 <= ex + 6}, 32'h1);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        s_regs();
        s_wave(1'b1, 2'h0, 15'h4, 15'h2, 15'h1, 2'h0, 4, 2, 1);
        for (int p = 0; p < 4; p++) s_wave(1'b1, 2'(p), 15'h5, 15'h3, 15'h2, 2'h0, 5 << p, 3 << p, 2 << p);
        s_hold();
        s_wave(1'b1, 2'h0, 15'h6, 15'h2, 15'h1, 2'h1, 6, 4, 1);
        s_wave(1'b0, 2'h0, 15'h6, 15'h2, 15'h5, 2'h0, 12, 3, 9);
        s_wave(1'b0, 2'h0, 15'h6, 15'h2, 15'h5, 2'h2, 12, 3, 3);
        s_reload(4'h4);
        s_reload(4'hF);
        tally_and_finish();
    end
endmodule
